// [logic/dbs_pkg.sv]
// Purpose : shared constants and types for the burst-of-four ddr sram port
// Assumes : x18 data path, two byte lanes of nine bits
// Notes   : link timing counts are in ref_clk edges on the controller side
package dbs_pkg;

    localparam int DBS_DW        = 18;   // data bits per beat
    localparam int DBS_LANE_W    = 9;    // bits per byte lane
    localparam int DBS_LANES     = 2;    // byte strobes per beat
    localparam int DBS_BEATS     = 4;    // fixed burst length
    localparam int DBS_AW        = 21;   // word address width
    localparam int DBS_DIV_W     = 2;    // k half period is two ref_clk periods
    localparam int DBS_SYNC_W    = 2;    // flops in an input synchroniser
    // ref_clk edge counts measured from the command launch edge
    localparam int DBS_CMD_HOLD  = 4;    // select stays low for one k period
    localparam int DBS_WR_BEAT0  = 4;    // first write beat launch
    localparam int DBS_WR_DONE   = 12;   // last write beat released
    localparam int DBS_RD_CAP0   = 10;   // first read beat capture
    localparam int DBS_RD_DONE   = 16;   // last read beat capture
    localparam int DBS_CNT_W     = 5;

    typedef logic [DBS_DW-1:0]    dbs_word_t;
    typedef logic [DBS_LANES-1:0] dbs_strb_t;

    typedef enum logic [1:0] {
        DBS_RUN,
        DBS_DRAIN,
        DBS_HALT
    } dbs_clk_state_e;

endpackage : dbs_pkg

// [logic/dbs_link_if.sv]
// Purpose : pins between the memory controller and the burst sram
// Assumes : read data enable is resolved by whoever looks at the wire
// Notes   : no clocking block; both ends are plain logic
`timescale 1ns/10ps
interface dbs_link_if #(parameter int AW = dbs_pkg::DBS_AW);
    logic                    k_clk;            // input clock, k# is its inverse
    logic                    c_clk;            // output clock, c# is its inverse
    logic                    rd_n;             // read select
    logic                    wr_n;             // write select
    logic [AW-1:0]           addr;             // burst base address
    logic [dbs_pkg::DBS_DW-1:0] d;             // write data beat
    logic                    byte_strobe_lo_n; // writes bits 0..8
    logic                    byte_strobe_hi_n; // writes bits 9..17
    logic [dbs_pkg::DBS_DW-1:0] q;             // read data beat
    logic                    q_oe;             // read data driven

    modport ctrl (
        output k_clk, c_clk, rd_n, wr_n, addr, d, byte_strobe_lo_n, byte_strobe_hi_n,
        input  q, q_oe
    );
    modport mem (
        input  k_clk, c_clk, rd_n, wr_n, addr, d, byte_strobe_lo_n, byte_strobe_hi_n,
        output q, q_oe
    );
endinterface : dbs_link_if

// [logic/dbs_sync2.sv]
// Purpose : two flop synchroniser for a bus sampled on ref_clk
// Assumes : the bus is stable for several ref_clk periods around use
// Notes   : first stage is read by the second stage only
`timescale 1ns/10ps
module dbs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // plain double flop, no reset needed on a data path
    always_ff @(posedge clk) begin
        meta_r <= din;
        dout   <= meta_r;
    end
endmodule : dbs_sync2

// [logic/dbs_sram_ctl.sv]
// Purpose : memory controller end, issues bursts and makes the k clock
// Assumes : ref_clk at 200 MHz, k runs at a quarter of it
// Notes   : one burst of each type in flight; spacing wider than the minimum
`timescale 1ns/10ps
module dbs_sram_ctl #(
    parameter int AW = dbs_pkg::DBS_AW
) (
    input  wire logic                                     ref_clk,
    input  wire logic                                     sys_rst,
    input  wire logic                                     c_tied,
    input  wire logic                                     cmd_valid,
    input  wire logic                                     cmd_write,
    input  wire logic [AW-1:0]                            cmd_addr,
    input  wire logic [dbs_pkg::DBS_BEATS*dbs_pkg::DBS_DW-1:0] cmd_wdata,
    input  wire logic [dbs_pkg::DBS_BEATS*dbs_pkg::DBS_LANES-1:0] cmd_strobe_n,
    output logic                                          cmd_ready,
    output logic                                          rsp_valid,
    output logic [dbs_pkg::DBS_BEATS*dbs_pkg::DBS_DW-1:0] rsp_rdata,
    input  wire logic                                     stop_req,
    output logic                                          stopped,
    dbs_link_if.ctrl                                      lnk
);
    import dbs_pkg::*;

    logic [DBS_DIV_W-1:0] div_r;
    logic [DBS_CNT_W-1:0] rcnt_r, wcnt_r;
    logic                 k_r, c_r, rd_n_r, wr_n_r, bl_r, bh_r, rsp_valid_r;
    logic [AW-1:0]        addr_r;
    dbs_word_t            d_r;
    logic [DBS_BEATS*DBS_DW-1:0]    wbuf_r, rbuf_r;
    logic [DBS_BEATS*DBS_LANES-1:0] wstb_r;
    dbs_clk_state_e       cst_r;
    logic                 launch, idle, go;
    logic [DBS_DIV_W-1:0] div_nxt;
    logic [DBS_DW:0]      rx_sync;
    logic [DBS_CNT_W-1:0] rb, wb;

    ////////////////////////////////////////////////////////////////////////
    // launch only mid low half so selects settle before the k rise
    assign launch    = (div_r == '0) && (cst_r == DBS_RUN);
    assign idle      = (rcnt_r == '0) && (wcnt_r == '0);
    // a read one k cycle behind a write would fetch before that write
    // commits and miss the forward path, so hold it back one k cycle
    assign cmd_ready = launch && !sys_rst && !stop_req
                       && (cmd_write ? (wcnt_r == '0)
                                     : (rcnt_r == '0
                                        && wcnt_r != DBS_CNT_W'(DBS_WR_BEAT0)));
    assign go        = cmd_valid && cmd_ready;
    assign div_nxt   = div_r + 1'b1;
    assign rb        = rcnt_r - DBS_CNT_W'(DBS_RD_CAP0);
    assign wb        = wcnt_r - DBS_CNT_W'(DBS_WR_BEAT0);
    assign lnk.k_clk = k_r;
    assign lnk.c_clk = c_r;
    assign lnk.rd_n  = rd_n_r;
    assign lnk.wr_n  = wr_n_r;
    assign lnk.addr  = addr_r;
    assign lnk.d     = d_r;
    assign lnk.byte_strobe_lo_n = bl_r;
    assign lnk.byte_strobe_hi_n = bh_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rbuf_r;
    assign stopped   = (cst_r == DBS_HALT);

    ////////////////////////////////////////////////////////////////////////
    // clock divider and stop handling; bursts finish before k halts
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cst_r <= DBS_RUN;
            div_r <= '0;
            k_r   <= 1'b0;
            c_r   <= c_tied;
        end else begin
            // halt on the last phase so the divider freezes at zero, k low
            unique case (cst_r)
                DBS_RUN:   if (stop_req && div_r == '0 && !go) cst_r <= DBS_DRAIN;
                DBS_DRAIN: if (idle && div_r == '1) cst_r <= DBS_HALT;
                DBS_HALT:  if (!stop_req && div_r == '0) cst_r <= DBS_RUN;
            endcase
            if (cst_r != DBS_HALT) div_r <= div_nxt;
            k_r <= (cst_r != DBS_HALT) ? div_nxt[DBS_DIV_W-1] : k_r;
            c_r <= c_tied | ((cst_r != DBS_HALT) ? div_nxt[DBS_DIV_W-1] : k_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command and write beat launch; strobes high outside write beats
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            addr_r <= '0;
            d_r    <= '0;
            bl_r   <= 1'b1;
            bh_r   <= 1'b1;
            wbuf_r <= '0;
            wstb_r <= '1;
        end else begin
            if (go) begin
                rd_n_r <= cmd_write;
                wr_n_r <= !cmd_write;
                addr_r <= cmd_addr;
                if (cmd_write) begin
                    wbuf_r <= cmd_wdata;
                    wstb_r <= cmd_strobe_n;
                end
            end else if (rcnt_r == DBS_CNT_W'(DBS_CMD_HOLD) ||
                         wcnt_r == DBS_CNT_W'(DBS_CMD_HOLD)) begin
                rd_n_r <= 1'b1;
                wr_n_r <= 1'b1;
            end
            if (wcnt_r >= DBS_CNT_W'(DBS_WR_BEAT0) && wcnt_r < DBS_CNT_W'(DBS_WR_DONE)
                && !wcnt_r[0]) begin
                d_r  <= wbuf_r[wb[DBS_CNT_W-1:1]*DBS_DW +: DBS_DW];
                bl_r <= wstb_r[wb[DBS_CNT_W-1:1]*DBS_LANES];
                bh_r <= wstb_r[wb[DBS_CNT_W-1:1]*DBS_LANES + 1];
            end else if (wcnt_r == DBS_CNT_W'(DBS_WR_DONE)) begin
                bl_r <= 1'b1;
                bh_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst counters; one of each type in flight keeps spacing legal
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rcnt_r <= '0;
            wcnt_r <= '0;
        end else begin
            if (go && !cmd_write) rcnt_r <= DBS_CNT_W'(1);
            else if (rcnt_r == DBS_CNT_W'(DBS_RD_DONE)) rcnt_r <= '0;
            else if (rcnt_r != '0) rcnt_r <= rcnt_r + 1'b1;
            if (go && cmd_write) wcnt_r <= DBS_CNT_W'(1);
            else if (wcnt_r == DBS_CNT_W'(DBS_WR_DONE)) wcnt_r <= '0;
            else if (wcnt_r != '0) wcnt_r <= wcnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data crosses through two flops before capture
    dbs_sync2 #(.W(DBS_DW + 1)) u_rx_sync (
        .clk  (ref_clk),
        .din  ({lnk.q_oe, lnk.q}),
        .dout (rx_sync)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rbuf_r      <= '0;
            rsp_valid_r <= 1'b0;
        end else begin
            if (rcnt_r >= DBS_CNT_W'(DBS_RD_CAP0) && rcnt_r <= DBS_CNT_W'(DBS_RD_DONE)
                && !rcnt_r[0])
                rbuf_r[rb[DBS_CNT_W-1:1]*DBS_DW +: DBS_DW] <= rx_sync[DBS_DW-1:0];
            rsp_valid_r <= (rcnt_r == DBS_CNT_W'(DBS_RD_DONE));
        end
    end
endmodule : dbs_sram_ctl

// [logic/dbs_sram_dev.sv]
// Purpose : burst-of-four ddr sram, command, beat and coherency timing
// Assumes : k and c are in phase when c is used; no reset pin exists
// Notes   : pipelines flush themselves after three idle k cycles
`timescale 1ns/10ps

// What this block does
// - read starts on read select low at k rise
// - write starts on write select low at k rise
// - every burst moves exactly four beats
// - reference: read at t, write at t+1
// - read beats at t+1.5, 2.0, 2.5, 3.0
// - controller drives write beats t+2.0 to t+3.5
// - controller spaces same type commands at least four edges
// - same type command on next edge discarded
// - both selects after idle: read wins
// - controller drains bursts before stopping k
// - masked beats only within an accepted write
// - lo strobe writes bits 0-8, hi 9-17
// - output clocks tied high: beats timed on k
// - burst addresses advance base plus one, two, three
// - idle read select never cuts a read
// - reads fetched on the edge a write commits return buffered data
module dbs_sram_dev #(
    parameter int AW = dbs_pkg::DBS_AW
) (
    dbs_link_if.mem   lnk,
    input  wire logic out_clk_tied
);
    import dbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage and pipeline state
    dbs_word_t     mem [2**AW];
    logic          rd_acc_r, rd_p1_r, rd_p2_r;
    logic          wr_acc_r, wr_p1_r, wr_p2_r;
    logic          idle_prev_r;
    logic [AW-1:0] ra_r, wa_r, wa_c_r;
    dbs_word_t     rbuf_r [DBS_BEATS];
    dbs_word_t     wd_pos_r [2];
    dbs_word_t     wd_neg_r [2];
    dbs_strb_t     ws_pos_r [2];
    dbs_strb_t     ws_neg_r [2];
    dbs_word_t     wb_d [DBS_BEATS];
    dbs_strb_t     wb_s [DBS_BEATS];
    dbs_word_t     fetch [DBS_BEATS];
    logic          rd_take, wr_take, oclk;
    dbs_word_t     q_pos_r, q_neg_r;
    logic          oe_pos_r, oe_neg_r;
    dbs_strb_t     strb_in;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // linear burst order, wraps at the top of the array
    function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] base,
                                                input int            beat);
        beat_addr = base + AW'(beat);
    endfunction : beat_addr

    // per lane merge, a low strobe lets that lane through
    function automatic dbs_word_t lane_merge(input dbs_word_t old_w,
                                             input dbs_word_t new_w,
                                             input dbs_strb_t strb_n);
        dbs_word_t res;
        res = old_w;
        for (int l = 0; l < DBS_LANES; l++) begin
            if (!strb_n[l]) res[l*DBS_LANE_W +: DBS_LANE_W] = new_w[l*DBS_LANE_W +: DBS_LANE_W];
        end
        lane_merge = res;
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////
    // command decode at the k rise
    assign strb_in = {lnk.byte_strobe_hi_n, lnk.byte_strobe_lo_n};

    always_comb begin
        rd_take = !lnk.rd_n && !rd_acc_r;
        wr_take = !lnk.wr_n && !wr_acc_r
                  && !(idle_prev_r && !lnk.rd_n);
    end

    ////////////////////////////////////////////////////////////////////////
    // read command pipeline; a high select only stops new reads
    always_ff @(posedge lnk.k_clk) begin
        rd_acc_r    <= rd_take;
        rd_p1_r     <= rd_acc_r;
        rd_p2_r     <= rd_p1_r;
        idle_prev_r <= lnk.rd_n && lnk.wr_n;
        if (rd_take) ra_r <= lnk.addr;
    end

    ////////////////////////////////////////////////////////////////////////
    // write command pipeline; address moves to a commit copy so a
    // following write may reuse the capture register
    always_ff @(posedge lnk.k_clk) begin
        wr_acc_r <= wr_take;
        wr_p1_r  <= wr_acc_r;
        wr_p2_r  <= wr_p1_r;
        if (wr_take) wa_r <= lnk.addr;
        if (wr_acc_r) wa_c_r <= wa_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // late write beats: one and three on k, two and four on k#
    always_ff @(posedge lnk.k_clk) begin
        if (wr_acc_r) begin
            wd_pos_r[0] <= lnk.d;
            ws_pos_r[0] <= strb_in;
        end
        if (wr_p1_r) begin
            wd_pos_r[1] <= lnk.d;
            ws_pos_r[1] <= strb_in;
        end
    end

    always_ff @(negedge lnk.k_clk) begin
        if (wr_p1_r) begin
            wd_neg_r[0] <= lnk.d;
            ws_neg_r[0] <= strb_in;
        end
        if (wr_p2_r) begin
            wd_neg_r[1] <= lnk.d;
            ws_neg_r[1] <= strb_in;
        end
    end

    // write buffer viewed in burst order
    always_comb begin
        for (int i = 0; i < DBS_BEATS; i++) begin
            wb_d[i] = (i % 2 == 0) ? wd_pos_r[i/2] : wd_neg_r[i/2];
            wb_s[i] = (i % 2 == 0) ? ws_pos_r[i/2] : ws_neg_r[i/2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array commit once the fourth beat is in; all-high beats leave
    // their word untouched
    always_ff @(posedge lnk.k_clk) begin
        if (wr_p2_r) begin
            for (int i = 0; i < DBS_BEATS; i++) begin
                mem[beat_addr(wa_c_r, i)] <= lane_merge(mem[beat_addr(wa_c_r, i)],
                                                        wb_d[i], wb_s[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read fetch; a write committing on the same edge is forwarded from
    // its buffer so the read never sees stale array contents
    always_comb begin
        for (int i = 0; i < DBS_BEATS; i++) begin
            fetch[i] = mem[beat_addr(ra_r, i)];
            for (int j = 0; j < DBS_BEATS; j++) begin
                if (wr_p2_r && beat_addr(wa_c_r, j) == beat_addr(ra_r, i))
                    fetch[i] = lane_merge(fetch[i], wb_d[j], wb_s[j]);
            end
        end
    end

    always_ff @(posedge lnk.k_clk) begin
        if (rd_acc_r) begin
            for (int i = 0; i < DBS_BEATS; i++) rbuf_r[i] <= fetch[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output clock choice; with c held high the k pair times the data
    assign oclk = out_clk_tied ? lnk.k_clk : lnk.c_clk;

    // beats two and four on the true output edge
    always_ff @(posedge oclk) begin
        oe_pos_r <= rd_p1_r || rd_p2_r;
        if (rd_p1_r) q_pos_r <= rbuf_r[1];
        else if (rd_p2_r) q_pos_r <= rbuf_r[3];
    end

    // beats one and three on the complementary output edge
    always_ff @(negedge oclk) begin
        oe_neg_r <= rd_p1_r || rd_p2_r;
        if (rd_p1_r) q_neg_r <= rbuf_r[0];
        else if (rd_p2_r) q_neg_r <= rbuf_r[2];
    end

    // ddr mux: high half shows the true edge register, low half the other
    assign lnk.q    = oclk ? q_pos_r : q_neg_r;
    assign lnk.q_oe = oclk ? oe_pos_r : oe_neg_r;

endmodule : dbs_sram_dev

// [testbench/dbs_link_props.sv]
// Purpose : link-side checks for the burst-of-four sram port
// Assumes : k rises sample commands; q_oe marks driven read beats
// Notes   : take flags follow the link rules, not the device code
`timescale 1ns/10ps
module dbs_link_props (
    input wire logic k_clk,
    input wire logic sys_rst,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic byte_strobe_lo_n,
    input wire logic byte_strobe_hi_n,
    input wire logic q_oe
);
    logic       rd_prev_r;
    logic       wr_prev_r;
    logic       idle_prev_r;
    logic       rd_t_r;
    logic [2:0] warm_r;
    logic       rd_take;
    logic       wr_take;

    ////////////////////////////////////////////////////////////////////////
    // commands the device should accept
    assign rd_take = !rd_n && !rd_prev_r;
    assign wr_take = !wr_n && !wr_prev_r && !(!rd_n && idle_prev_r);

    // async clear: k stands still while the controller is in reset
    always_ff @(posedge k_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_prev_r   <= 1'b0;
            wr_prev_r   <= 1'b0;
            idle_prev_r <= 1'b0;
            rd_t_r      <= 1'b0;
            warm_r      <= 3'h0;
        end else begin
            rd_prev_r   <= rd_take;
            wr_prev_r   <= wr_take;
            idle_prev_r <= rd_n && wr_n;
            rd_t_r      <= rd_take;
            warm_r      <= (warm_r == 3'h4) ? warm_r : warm_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_rd_beats_rise: assert property (@(posedge k_clk) disable iff (sys_rst)
        rd_take |-> ##2 q_oe ##1 q_oe) else $error("read beats missing at k rise");
    a_rd_beats_fall: assert property (@(negedge k_clk) disable iff (sys_rst)
        rd_t_r |-> ##2 q_oe ##1 q_oe) else $error("read beats missing at k fall");
    // device has no reset, so wait out its flush before judging idle drive
    a_rd_idle_hiz: assert property (@(posedge k_clk) disable iff (sys_rst)
        warm_r == 3'h4 |-> q_oe == ($past(rd_take, 2) || $past(rd_take, 3)))
        else $error("read data driven outside a burst");
    a_rd_four_only: assert property (@(posedge k_clk) disable iff (sys_rst)
        rd_take ##2 !rd_take |-> ##2 !q_oe) else $error("read burst longer than four");
    a_nop_keeps_rd: assert property (@(posedge k_clk) disable iff (sys_rst)
        rd_take ##1 rd_n [*2] |-> q_oe) else $error("idle select cut a read");
    a_rd_spacing: assert property (@(posedge k_clk) disable iff (sys_rst)
        !rd_n |=> rd_n) else $error("reads on adjacent k rises");
    a_wr_spacing: assert property (@(posedge k_clk) disable iff (sys_rst)
        !wr_n |=> wr_n) else $error("writes on adjacent k rises");
    a_strobe_in_burst: assert property (@(posedge k_clk) disable iff (sys_rst)
        (!byte_strobe_lo_n || !byte_strobe_hi_n) |-> ($past(wr_take) || $past(wr_take, 2)))
        else $error("byte strobe low outside a write");
endmodule : dbs_link_props

// [testbench/test_ddr_burst4_sram_port.sv]
// Purpose : self-checking bench for the burst-of-four ddr sram port
// Assumes : AW cut to 8; controller k is a quarter of ref_clk
// Notes   : a second device is driven by hand to break command spacing
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("FAIL %s expected %h seen %h", nm, e, g); end end
module test_ddr_burst4_sram_port;
    import dbs_pkg::*;
    localparam int        AW = 8;
    localparam dbs_word_t ZW = 18'h0_0f0f;
    logic                        ref_clk = 1'b0;
    logic                        sys_rst = 1'b1;
    logic                        c_tied = 1'b0;
    logic                        cmd_valid = 1'b0;
    logic                        cmd_write = 1'b0;
    logic                        stop_req = 1'b0;
    logic [AW-1:0]               cmd_addr = '0;
    logic [DBS_BEATS*DBS_DW-1:0] cmd_wdata = '0;
    logic [7:0]                  cmd_strobe_n = '1;
    logic                        cmd_ready, rsp_valid, stopped, oef;
    logic [DBS_BEATS*DBS_DW-1:0] rsp_rdata, exp_r;
    dbs_word_t                   mem_m [256];
    dbs_word_t                   pb [4] = '{18'h1_2345, 18'h2_3456, 18'h0_789a, 18'h3_bcde};
    dbs_word_t                   qr, qf;
    int                          n_mismatch = 0, n_tests = 0, cyc = 0;

    dbs_link_if #(.AW(AW)) lnk ();
    dbs_link_if #(.AW(AW)) lnk_b ();
    dbs_sram_ctl #(.AW(AW)) u_dbs_sram_ctl (.ref_clk, .sys_rst, .c_tied, .cmd_valid, .cmd_write,
        .cmd_addr, .cmd_wdata, .cmd_strobe_n, .cmd_ready, .rsp_valid, .rsp_rdata, .stop_req,
        .stopped, .lnk(lnk.ctrl));
    dbs_sram_dev #(.AW(AW)) u_dbs_sram_dev (.lnk(lnk.mem), .out_clk_tied(c_tied));
    dbs_sram_dev #(.AW(AW)) u_dbs_sram_dev_b (.lnk(lnk_b.mem), .out_clk_tied(1'b1));
    dbs_link_props u_dbs_link_props (.k_clk(lnk.k_clk), .sys_rst(sys_rst), .rd_n(lnk.rd_n),
        .wr_n(lnk.wr_n), .byte_strobe_lo_n(lnk.byte_strobe_lo_n),
        .byte_strobe_hi_n(lnk.byte_strobe_hi_n), .q_oe(lnk.q_oe));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // user port command, held until the take edge; model follows the strobes
    task automatic put_cmd(input logic wr, input logic [AW-1:0] a,
                           input logic [DBS_BEATS*DBS_DW-1:0] wd, input logic [7:0] sn);
        logic [AW-1:0] ix;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_strobe_n = sn;
        for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (int b = 0; b < 4; b++) begin
            ix = a + AW'(b);
            if (wr && !sn[2*b]) mem_m[ix][8:0] = wd[18*b +: 9];
            if (wr && !sn[2*b+1]) mem_m[ix][17:9] = wd[18*b+9 +: 9];
        end
    endtask : put_cmd

    task automatic rd_exp(input logic [AW-1:0] a);
        for (int b = 0; b < 4; b++) exp_r[18*b +: 18] = mem_m[a + AW'(b)];
    endtask : rd_exp

    task automatic rd_wait(input string nm);
        for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
        `CHK(nm, exp_r, rsp_rdata)
    endtask : rd_wait

    task automatic rd_chk(input logic [AW-1:0] a);
        rd_exp(a);
        put_cmd(1'b0, a, '0, '1);
        rd_wait("read burst");
    endtask : rd_chk

    // one 12 ns k period on the hand-driven link; strobes are {hi, lo}
    task automatic kc(input logic rn, input logic wn, input logic [AW-1:0] a,
                      input dbs_word_t dr, input dbs_word_t df, input logic [1:0] sr,
                      input logic [1:0] sf);
        lnk_b.rd_n = rn;
        lnk_b.wr_n = wn;
        lnk_b.addr = a;
        lnk_b.d = dr;
        {lnk_b.byte_strobe_hi_n, lnk_b.byte_strobe_lo_n} = sr;
        #3 lnk_b.k_clk = 1'b1;
        #1 qr = lnk_b.q;
        #2 lnk_b.d = df;
        {lnk_b.byte_strobe_hi_n, lnk_b.byte_strobe_lo_n} = sf;
        #3 lnk_b.k_clk = 1'b0;
        #1 qf = lnk_b.q;
        oef = lnk_b.q_oe;
        #2;
    endtask : kc

    // read of 0x40; low strobes in its shadow catch any write wrongly taken
    task automatic rd_b(input logic rn2, input logic wn1);
        kc(1'b0, wn1, 8'h40, ZW, ZW, 2'b11, 2'b11);
        kc(rn2, 1'b1, 8'h60, ZW, ZW, 2'b00, 2'b00);
        `CHK("beat one", pb[0], qf)
        kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b00, 2'b00);
        `CHK("beat two", pb[1], qr)
        `CHK("beat three", pb[2], qf)
        kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b11, 2'b11);
        `CHK("beat four", pb[3], qr)
        `CHK("drive after burst", 1'b0, oef)
    endtask : rd_b

    ////////////////////////////////////////////////////////////////////////
    initial begin
        lnk_b.k_clk = 1'b0;
        lnk_b.c_clk = 1'b1;
        {lnk_b.rd_n, lnk_b.wr_n, lnk_b.byte_strobe_hi_n, lnk_b.byte_strobe_lo_n} = 4'hf;
        lnk_b.addr = '0;
        lnk_b.d = ZW;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (40) @(negedge ref_clk);
        put_cmd(1'b1, 8'h10, {18'h0_4444, 18'h0_3333, 18'h0_2222, 18'h0_1111}, 8'h00);
        put_cmd(1'b1, 8'h10, {18'h3_cccc, 18'h2_bbbb, 18'h1_aaaa, 18'h3_9999}, 8'hd8);
        rd_chk(8'h10);
        put_cmd(1'b1, 8'h12, {4{18'h2_5a5a}}, 8'h00);
        repeat (4) @(negedge ref_clk);
        rd_chk(8'h12);
        put_cmd(1'b1, 8'hfe, {18'h0_00f1, 18'h0_00f0, 18'h0_00ff, 18'h0_00fe}, 8'h00);
        rd_chk(8'hfe);
        rd_exp(8'h10);
        put_cmd(1'b0, 8'h10, '0, '1);
        put_cmd(1'b1, 8'h20, {18'h1_0003, 18'h1_0002, 18'h1_0001, 18'h1_0000}, 8'h00);
        rd_wait("read beside write");
        rd_chk(8'h20);
        rd_exp(8'h20);
        put_cmd(1'b0, 8'h20, '0, '1);
        stop_req = 1'b1;
        rd_wait("read across stop");
        for (int i = 0; i < 40 && stopped !== 1'b1; i++) @(negedge ref_clk);
        repeat (8) @(negedge ref_clk);
        `CHK("stopped", 1'b1, stopped)
        `CHK("k held low", 1'b0, lnk.k_clk)
        `CHK("ready while stopped", 1'b0, cmd_ready)
        stop_req = 1'b0;
        rd_chk(8'h10);
        c_tied = 1'b1;
        sys_rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (40) @(negedge ref_clk);
        `CHK("output clock tied", 1'b1, lnk.c_clk)
        put_cmd(1'b1, 8'h30, {18'h0_0c03, 18'h0_0c02, 18'h0_0c01, 18'h0_0c00}, 8'h00);
        rd_chk(8'h30);
        rd_chk(8'h10);
        repeat (4) kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b11, 2'b11);
        kc(1'b1, 1'b0, 8'h40, ZW, ZW, 2'b11, 2'b11);
        kc(1'b1, 1'b1, 8'h00, pb[0], pb[1], 2'b00, 2'b00);
        kc(1'b1, 1'b1, 8'h00, pb[2], pb[3], 2'b00, 2'b00);
        repeat (2) kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b11, 2'b11);
        rd_b(1'b1, 1'b1);
        rd_b(1'b1, 1'b0);
        rd_b(1'b1, 1'b1);
        rd_b(1'b0, 1'b1);
        kc(1'b1, 1'b0, 8'h60, ZW, ZW, 2'b11, 2'b11);
        kc(1'b1, 1'b0, 8'h40, ZW, ZW, 2'b00, 2'b00);
        repeat (2) kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b00, 2'b00);
        kc(1'b1, 1'b1, 8'h00, ZW, ZW, 2'b11, 2'b11);
        rd_b(1'b1, 1'b1);
        print_verdict();
    end
endmodule : test_ddr_burst4_sram_port
